// ---- core/mlfp_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit classic wishbone, word aligned registers
// Notes:   currents in mA, amplitudes in 9-bit command units
`ifndef MLFP_MAP_SVH
`define MLFP_MAP_SVH
// register offsets (byte addresses)
`define MLFP_CFG0_ADR     8'h00
`define MLFP_CFG1_ADR     8'h04
`define MLFP_STAT_ADR     8'h08
// cfg0 field positions
`define MLFP_ACC_SEL_LSB  0
`define MLFP_LCK_SEL_LSB  4
`define MLFP_KTW_SEL_LSB  8
`define MLFP_LOCK_EN_LSB  16
`define MLFP_MECH_EN_BIT  24
`define MLFP_IND_EN_BIT   25
`define MLFP_MECH_MD_BIT  26
// cfg1 field positions
`define MLFP_RM_LSB       0
`define MLFP_KT_LSB       8
// status field positions
`define MLFP_LOCKED_BIT   0
`define MLFP_OC_BIT       1
`define MLFP_HIZ_BIT      2
`define MLFP_STATE_LSB    4
`define MLFP_CODE_LSB     8
// reset values and writable masks
`define MLFP_CFG0_RST     32'h033f_0135
`define MLFP_CFG0_MASK    32'h073f_037f
`define MLFP_CFG1_RST     32'h0000_2010
`define MLFP_CFG1_MASK    32'h0000_7f7f
// scaling of thresholds and estimates
`define MLFP_ILIM_STEP_MA 12'h064
`define MLFP_ILCK_STEP_MA 12'h0fa
`define MLFP_NOMOTOR_MA   12'h08c
`define MLFP_IR_SHIFT     8
`define MLFP_KT_SHIFT     6
`define MLFP_KTC_SHIFT    8
`define MLFP_ABN_MARGIN   10'h020
// timing
`define MLFP_CLK_MHZ      50
`define MLFP_LOCK_QUAL_MS 100
`define MLFP_LOCK_OFF_MS  5000
`define MLFP_IND_AVS_US   20
`define MLFP_IND_AVS_CYC  (`MLFP_IND_AVS_US * `MLFP_CLK_MHZ)
`endif

// ---- core/mlfp_pkg.sv ----
// Purpose: types shared by the protection core
// Assumes: one-hot state coding
// Notes:   constants live in mlfp_map.svh
package mlfp_pkg;
  // fault sequencer states
  typedef enum logic [3:0] {
    ST_RUN     = 4'b0001,
    ST_SURGE   = 4'b0010,
    ST_WAIT    = 4'b0100,
    ST_RESTART = 4'b1000
  } mlfp_state_t;
  typedef logic [5:0]  mlfp_code_t;  // one bit per lock scheme
  typedef logic [8:0]  mlfp_amp_t;   // amplitude / speed units
  typedef logic [11:0] mlfp_ma_t;    // current in mA
endpackage

// ---- core/mlfp_dwell_if.sv ----
// Purpose: run/done pair between the core and a dwell timer
// Assumes: both ends on clk_i
// Notes:   done is a level while run is held long enough
`timescale 1ns/10ps
interface mlfp_dwell_if;
  logic run;   // condition present
  logic done;  // condition held for the full count
  modport tmr (input run, output done);
  modport usr (output run, input done);
endinterface

// ---- core/mlfp_dwell.sv ----
// Purpose: counts consecutive cycles of a held condition
// Assumes: run from same-clock logic
// Notes:   done rises on the CYCLES-th consecutive run cycle
`timescale 1ns/10ps
module mlfp_dwell #(
  parameter int unsigned CW     = 32,
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // timer port
  mlfp_dwell_if.tmr t
);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_r;  // cycles run has been held

  // count while run, restart when run drops
  always_ff @(posedge clk_i) begin
    if (rst_i || !t.run) begin
      cnt_r <= '0;
    end else if (cnt_r != LAST) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign t.done = t.run && (cnt_r == LAST);
endmodule

// ---- core/mlfp_top.sv ----
// Purpose: lock detect, fault retry, current limit and anti-surge core
// Assumes: estimates and loop flags from same-clock motor logic
// Notes:   overcurrent and 24 V comparator pins are synchronised
// Contract
// R1: start-up current cap lowers amplitude, no fault
// R2: cap = I(sel) * Rm + speed * Kt
// R3: current cap only in closed loop, never stops
// R4: overcurrent always on, drive resumes when clear
// R5: six lock schemes each gated by enable bit
// R6: lock sets flag and code, restart clears
// R7: code bits set even if scheme disabled
// R8: lock tri-states bridge, runs anti-surge on entry
// R9: after fault tri-state, wait retry delay, restart
// R10: low-side current over threshold trips lock
// R11: software sets lock current above accel limit
// R12: bemf far above amplitude for qualify time locks
// R13: integrated Ktc outside window for qualify time locks
// R14: no-motor if phase U current not above 140mA
// R15: open-loop: no bemf one cycle after handoff
// R16: closed loop period over twice previous locks
// R17: mechanical and inductive anti-surge separately enabled
// R18: mechanical guard keeps amplitude at or above bemf
// R19: mode 0: always keep amplitude above bemf
// R20: mode 1: guard only once supply reaches 24V
// R21: tach output held high while locked
// R22: qualify and retry times are parameterised counters
`timescale 1ns/10ps
`include "mlfp_map.svh"
module mlfp_top
  import mlfp_pkg::*;
#(
  parameter int unsigned QUAL_CYC  = `MLFP_LOCK_QUAL_MS * 1000 * `MLFP_CLK_MHZ,
  parameter int unsigned RETRY_CYC = `MLFP_LOCK_OFF_MS * 1000 * `MLFP_CLK_MHZ,
  parameter int unsigned PER_W     = 24
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // motor estimates, same clock
  input  wire logic [8:0]  speed_i,
  input  wire logic [8:0]  speed_cmd_i,
  input  wire logic [11:0] phase_u_ma_i,
  input  wire logic [11:0] low_side_ma_i,
  input  wire logic        closed_loop_i,
  input  wire logic        handoff_i,
  input  wire logic        ol_cycle_i,
  input  wire logic        bemf_zc_i,
  // comparator pins, asynchronous
  input  wire logic        oc_pin_i,
  input  wire logic        vcc_24v_pin_i,
  // bridge and status outputs
  output logic      [8:0]  amp_o,
  output logic             bridge_hiz_o,
  output logic             anti_surge_o,
  output logic             restart_o,
  output logic             speed_tach_high_o,
  output logic             motor_locked_o
);
  localparam int unsigned IND_CYC = `MLFP_IND_AVS_CYC;

  // configuration registers
  logic [31:0] cfg0_r;              // selects, enables, modes
  logic [31:0] cfg1_r;              // phase resistance, bemf constant
  // fault state
  mlfp_state_t state_r;             // fault sequencer
  mlfp_state_t state_nxt;           // its next value
  mlfp_code_t  code_r;              // fault_cause_code
  mlfp_code_t  code_nxt;
  logic        locked_r;            // motor_locked_flag
  logic        locked_nxt;
  // pin synchronisers
  logic        oc_m_r, oc_s_r;      // overcurrent
  logic        v24_m_r, v24_s_r;    // supply at 24 V
  // estimator state
  mlfp_amp_t   amp_r;               // buffered amplitude
  logic [23:0] ktc_acc_r;           // bemf integral over half cycle
  logic [15:0] ktc_r;               // last measured constant
  logic        ktc_vld_r;           // ktc_r holds a closed-loop value
  logic        cl_d_r;              // closed loop, one cycle late
  logic        armed_r;             // open-loop cycle with no bemf
  logic [PER_W-1:0] per_r;          // current commutation period
  logic [PER_W-1:0] prev_r;         // previous commutation period
  logic        prev_vld_r;
  // bus
  logic        bus_req;

  // field views
  logic [3:0] accel_limit_threshold_sel;
  logic [2:0] lock_current_threshold_sel;
  logic [1:0] bemf_const_window_sel;
  logic [5:0] lock_scheme_enables;
  logic       mech_surge_guard_enable;
  logic       induct_surge_guard_enable;
  logic       mech_surge_guard_mode;
  logic [6:0] phase_resistance_setting;
  logic [6:0] bemf_constant_setting;
  assign accel_limit_threshold_sel  = cfg0_r[`MLFP_ACC_SEL_LSB +: 4];
  assign lock_current_threshold_sel = cfg0_r[`MLFP_LCK_SEL_LSB +: 3];
  assign bemf_const_window_sel      = cfg0_r[`MLFP_KTW_SEL_LSB +: 2];
  assign lock_scheme_enables        = cfg0_r[`MLFP_LOCK_EN_LSB +: 6];
  assign mech_surge_guard_enable    = cfg0_r[`MLFP_MECH_EN_BIT];
  assign induct_surge_guard_enable  = cfg0_r[`MLFP_IND_EN_BIT];
  assign mech_surge_guard_mode      = cfg0_r[`MLFP_MECH_MD_BIT];
  assign phase_resistance_setting   = cfg1_r[`MLFP_RM_LSB +: 7];
  assign bemf_constant_setting      = cfg1_r[`MLFP_KT_LSB +: 7];

  // saturate a wide voltage to amplitude units
  function automatic mlfp_amp_t sat9(input logic [19:0] v);
    sat9 = (v > 20'h001ff) ? 9'h1ff : v[8:0];
  endfunction

  // ---------------- wishbone slave ----------------
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // read mux, unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `MLFP_CFG0_ADR: wb_dat_o <= cfg0_r;
        `MLFP_CFG1_ADR: wb_dat_o <= cfg1_r;
        `MLFP_STAT_ADR: begin
          wb_dat_o                          <= 32'h0000_0000;
          wb_dat_o[`MLFP_LOCKED_BIT]        <= locked_r;
          wb_dat_o[`MLFP_OC_BIT]            <= oc_s_r;
          wb_dat_o[`MLFP_HIZ_BIT]           <= bridge_hiz_o;
          wb_dat_o[`MLFP_STATE_LSB +: 4]    <= state_r;
          wb_dat_o[`MLFP_CODE_LSB +: 6]     <= code_r;
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // byte-lane writes land on the ack edge, reserved bits held at zero
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cfg0_r[8*b +: 8] <= 8'(`MLFP_CFG0_RST >> (8*b));
          cfg1_r[8*b +: 8] <= 8'(`MLFP_CFG1_RST >> (8*b));
        end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[b]) begin
          if (wb_adr_i == `MLFP_CFG0_ADR) begin
            cfg0_r[8*b +: 8] <= wb_dat_i[8*b +: 8] & 8'(`MLFP_CFG0_MASK >> (8*b));
          end
          if (wb_adr_i == `MLFP_CFG1_ADR) begin
            cfg1_r[8*b +: 8] <= wb_dat_i[8*b +: 8] & 8'(`MLFP_CFG1_MASK >> (8*b));
          end
        end
      end
    end
  endgenerate

  // ---------------- pin synchronisers ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_m_r  <= 1'b0;
      oc_s_r  <= 1'b0;
      v24_m_r <= 1'b0;
      v24_s_r <= 1'b0;
    end else begin
      oc_m_r  <= oc_pin_i;
      oc_s_r  <= oc_m_r;
      v24_m_r <= vcc_24v_pin_i;
      v24_s_r <= v24_m_r;
    end
  end

  // ---------------- voltage estimates ----------------
  logic [11:0] ilim_ma;     // selected acceleration current
  logic [11:0] ilck_ma;     // selected lock current
  logic [18:0] ir_lim;      // ilim * Rm
  logic [18:0] ir_u;        // phase U current * Rm
  logic [15:0] kt_prod;     // speed * Kt
  mlfp_amp_t   bemf_kt;     // bemf from speed and Kt
  mlfp_amp_t   bemf_cur;    // bemf from amplitude less I*R
  mlfp_amp_t   u_limit;     // acceleration voltage cap
  mlfp_amp_t   amp_cap;
  mlfp_amp_t   amp_nxt;
  logic        floor_on;    // mechanical guard active

  assign ilim_ma  = 12'((12'(accel_limit_threshold_sel) + 12'h001) * `MLFP_ILIM_STEP_MA);
  assign ilck_ma  = 12'((12'(lock_current_threshold_sel) + 12'h001) * `MLFP_ILCK_STEP_MA);
  assign ir_lim   = 19'(ilim_ma) * 19'(phase_resistance_setting);          // R2
  assign ir_u     = 19'(phase_u_ma_i) * 19'(phase_resistance_setting);     // R13
  assign kt_prod  = 16'(speed_i) * 16'(bemf_constant_setting);             // R12
  assign bemf_kt  = sat9(20'(kt_prod >> `MLFP_KT_SHIFT));
  assign u_limit  = sat9(20'(ir_lim >> `MLFP_IR_SHIFT) + 20'(bemf_kt));    // R2
  assign bemf_cur = (20'(amp_r) > 20'(ir_u >> `MLFP_IR_SHIFT))
                    ? 9'(20'(amp_r) - 20'(ir_u >> `MLFP_IR_SHIFT)) : 9'h000;

  // acceleration cap only in closed loop
  assign amp_cap  = (closed_loop_i && speed_cmd_i > u_limit) ? u_limit : speed_cmd_i; // R1 R3
  // mode 0 always, mode 1 only at 24 V
  assign floor_on = mech_surge_guard_enable
                    && (!mech_surge_guard_mode || v24_s_r);                // R17 R19 R20
  assign amp_nxt  = (floor_on && amp_cap < bemf_kt) ? bemf_kt : amp_cap;   // R18

  // buffered amplitude toward the bridge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amp_r <= 9'h000;
    end else begin
      amp_r <= amp_nxt;
    end
  end

  // ---------------- Ktc integration ----------------
  logic [15:0] kt_w;        // programmed constant, wide
  logic [15:0] kt_win;      // half window width
  assign kt_w   = 16'(bemf_constant_setting);
  assign kt_win = kt_w >> (2'h3 - bemf_const_window_sel);

  // integrate bemf between zero crossings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ktc_acc_r <= 24'h00_0000;
      ktc_r     <= 16'h0000;
      ktc_vld_r <= 1'b0;
    end else if (!closed_loop_i) begin
      ktc_acc_r <= 24'h00_0000;
      ktc_vld_r <= 1'b0;
    end else if (bemf_zc_i) begin
      ktc_r     <= 16'(ktc_acc_r >> `MLFP_KTC_SHIFT);                    // R13
      ktc_acc_r <= 24'(bemf_cur);
      ktc_vld_r <= 1'b1;
    end else begin
      ktc_acc_r <= ktc_acc_r + 24'(bemf_cur);
    end
  end

  // ---------------- commutation period ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !closed_loop_i) begin
      per_r      <= '0;
      prev_r     <= '0;
      prev_vld_r <= 1'b0;
    end else if (bemf_zc_i) begin
      prev_r     <= per_r;
      per_r      <= '0;
      prev_vld_r <= 1'b1;
    end else if (!(&per_r)) begin
      per_r <= per_r + 1'b1;
    end
  end

  // open-loop watch and loop-edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
      cl_d_r  <= 1'b0;
    end else begin
      cl_d_r <= closed_loop_i;
      if (!handoff_i || bemf_zc_i || closed_loop_i) begin
        armed_r <= 1'b0;
      end else if (ol_cycle_i) begin
        armed_r <= 1'b1;
      end
    end
  end

  // ---------------- lock conditions ----------------
  logic       running;
  logic [5:0] hit;          // conditions seen this cycle
  logic       lock_trip;
  logic       c0, c1, c2, c3, c4, c5;
  mlfp_dwell_if q1_if ();
  mlfp_dwell_if q2_if ();
  mlfp_dwell_if retry_if ();
  mlfp_dwell_if surge_if ();

  assign running = (state_r == ST_RUN) && !oc_s_r;
  assign c0 = low_side_ma_i > ilck_ma;                                     // R10
  assign c1 = closed_loop_i && (10'(bemf_kt) > 10'(amp_r) + `MLFP_ABN_MARGIN); // R12
  assign c2 = ktc_vld_r && ((ktc_r + kt_win < kt_w) || (ktc_r > kt_w + kt_win)); // R13
  assign c3 = closed_loop_i && !cl_d_r && (phase_u_ma_i <= `MLFP_NOMOTOR_MA); // R14
  assign c4 = ol_cycle_i && armed_r && !bemf_zc_i;                         // R15
  assign c5 = prev_vld_r && (per_r > {prev_r[PER_W-2:0], 1'b0});           // R16

  // held conditions qualified over the lock qualify time
  assign q1_if.run = running && c1;                                        // R22
  assign q2_if.run = running && c2;                                        // R22
  mlfp_dwell #(.CW(32), .CYCLES(QUAL_CYC)) u_qual1 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (q1_if)
  );
  mlfp_dwell #(.CW(32), .CYCLES(QUAL_CYC)) u_qual2 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (q2_if)
  );

  // every condition recorded, only enabled ones trip
  assign hit       = {c5, c4, c3, q2_if.done, q1_if.done, c0} & {6{running}}; // R7
  assign lock_trip = |(hit & lock_scheme_enables);                         // R5

  // retry wait and inductive surge window
  assign retry_if.run = (state_r == ST_WAIT);                              // R9 R22
  assign surge_if.run = (state_r == ST_SURGE);
  mlfp_dwell #(.CW(32), .CYCLES(RETRY_CYC)) u_retry (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (retry_if)
  );
  mlfp_dwell #(.CW(16), .CYCLES(IND_CYC)) u_surge (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (surge_if)
  );

  // ---------------- fault sequencer ----------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (lock_trip) begin
          // inductive guard runs on entry to tri-state
          state_nxt = induct_surge_guard_enable ? ST_SURGE : ST_WAIT;      // R8 R17
        end
      end
      ST_SURGE: begin
        if (surge_if.done) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (retry_if.done) begin
          state_nxt = ST_RESTART;                                          // R9
        end
      end
      ST_RESTART: state_nxt = ST_RUN;
      default:    state_nxt = ST_RUN;
    endcase
  end

  // flag and cause code, restart clears both, nothing sets outside ST_RUN
  always_comb begin
    if (state_r == ST_RESTART) begin
      code_nxt   = hit;                                                    // R6
      locked_nxt = lock_trip;
    end else begin
      code_nxt   = code_r | hit;                                           // R7
      locked_nxt = locked_r | lock_trip;                                   // R6 R10
    end
  end

  // state and fault records
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r  <= ST_RUN;
      code_r   <= 6'h00;
      locked_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      code_r   <= code_nxt;
      locked_r <= locked_nxt;
    end
  end

  // ---------------- registered outputs ----------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bridge_hiz_o      <= 1'b1;
      anti_surge_o      <= 1'b0;
      restart_o         <= 1'b0;
      speed_tach_high_o <= 1'b0;
      motor_locked_o    <= 1'b0;
      amp_o             <= 9'h000;
    end else begin
      bridge_hiz_o      <= oc_s_r || (state_nxt != ST_RUN);                // R4 R8
      anti_surge_o      <= (state_nxt == ST_SURGE) || (floor_on && amp_cap < bemf_kt); // R8
      restart_o         <= (state_nxt == ST_RESTART);                      // R9
      speed_tach_high_o <= locked_nxt;                                     // R21
      motor_locked_o    <= locked_nxt;
      amp_o             <= amp_nxt;
    end
  end
endmodule

// ---- dv/mlfp_checker.sv ----
// Purpose: port assertions for mlfp_top
// Assumes: one clock, synchronous reset
// Notes:   bound into every mlfp_top
`timescale 1ns/10ps
module mlfp_checker (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // protection ports
  input wire logic oc_pin_i,
  input wire logic bridge_hiz_o,
  input wire logic restart_o,
  input wire logic speed_tach_high_o,
  input wire logic motor_locked_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers one cycle after a taken request
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  // a lock floats the bridge and pins tach high
  a_lock_float: assert property (motor_locked_o |-> bridge_hiz_o && speed_tach_high_o)
    else $error("lock without float");
  a_lock_hold: assert property ($rose(motor_locked_o) |=> motor_locked_o [*8])
    else $error("lock released early");
  // retry comes from the floated state, flag clears after it
  a_restart_float: assert property (restart_o |-> bridge_hiz_o ##1 !restart_o)
    else $error("bad restart pulse");
  a_restart_clear: assert property (restart_o |=> !motor_locked_o)
    else $error("flag kept after restart");
  // overcurrent floats, clearing it resumes
  a_oc_float: assert property (oc_pin_i [*4] |-> bridge_hiz_o)
    else $error("overcurrent not floated");
  a_oc_resume: assert property (!oc_pin_i [*4] ##0 !motor_locked_o |-> !bridge_hiz_o)
    else $error("drive not resumed");
  // main scenarios seen
  c_lock: cover property ($rose(motor_locked_o));
  c_restart: cover property (restart_o);
  c_oc: cover property (oc_pin_i [*4] ##0 bridge_hiz_o && !motor_locked_o);
endmodule
bind mlfp_top mlfp_checker u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .oc_pin_i,
  .bridge_hiz_o, .restart_o, .speed_tach_high_o, .motor_locked_o
);

// ---- dv/mlfp_motor_model.sv ----
// Purpose: motor seen through the bridge
// Assumes: bench sets load, speed and zero cross period
// Notes:   no current flows while the bridge floats
`timescale 1ns/10ps
module mlfp_motor_model (
  // clock and bridge state
  input  wire logic        clk_i,
  input  wire logic        hiz_i,
  // operating point
  input  wire logic [11:0] load_ma_i,
  input  wire logic [8:0]  spd_i,
  input  wire logic [7:0]  zc_per_i,
  // estimates to the core
  output logic      [8:0]  speed_o = 9'h000,
  output logic      [11:0] phase_u_ma_o = 12'h000,
  output logic      [11:0] low_side_ma_o = 12'h000,
  output logic             bemf_zc_o = 1'b0
);
  logic [7:0] cnt_r = 8'h00;  // zero cross spacing
  // currents collapse once the bridge floats
  always_ff @(posedge clk_i) begin
    phase_u_ma_o  <= hiz_i ? 12'h000 : load_ma_i;
    low_side_ma_o <= hiz_i ? 12'h000 : load_ma_i;
    speed_o       <= spd_i;
  end
  // period 0 means a stalled rotor, no crossings
  always_ff @(posedge clk_i) begin
    cnt_r     <= (cnt_r >= zc_per_i) ? 8'h00 : cnt_r + 8'h01;
    bemf_zc_o <= (zc_per_i != 8'h00) && (cnt_r == zc_per_i);
  end
endmodule

// ---- dv/mlfp_top_tb_top.sv ----
// Purpose: directed bench for mlfp_top
// Assumes: qualify 20 and retry 40 cycles
// Notes:   low-side and no-motor lock trips use the motor model's load
`timescale 1ns/10ps
module mlfp_top_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1;     // clock and reset
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;                 // bus address
  logic [31:0] wb_dat = 32'h0, q, wb_dat_o;    // bus data
  logic        wb_ack_o, cl = 1'b0, ho = 1'b0, olc = 1'b0, oc = 1'b0, v24 = 1'b0;
  logic [11:0] load = 12'h0c8, pu, ls;         // motor currents
  logic [8:0]  spd = 9'h0c8, cmd = 9'h014, speed, amp_o;
  logic [7:0]  zper = 8'h00;                   // zero cross period
  logic        zc, hiz, surge, rst_o, tach, locked;
  int          mismatches = 0, n_checks = 0, n;
  always #10 clk_i = ~clk_i;
  mlfp_motor_model MOT (.clk_i, .hiz_i(hiz), .load_ma_i(load), .spd_i(spd),
    .zc_per_i(zper), .speed_o(speed), .phase_u_ma_o(pu), .low_side_ma_o(ls),
    .bemf_zc_o(zc));
  mlfp_top #(.QUAL_CYC(20), .RETRY_CYC(40)) DUT (.clk_i, .rst_i,
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o, .wb_ack_o, .speed_i(speed),
    .speed_cmd_i(cmd), .phase_u_ma_i(pu), .low_side_ma_i(ls), .closed_loop_i(cl),
    .handoff_i(ho), .ol_cycle_i(olc), .bemf_zc_i(zc), .oc_pin_i(oc),
    .vcc_24v_pin_i(v24), .amp_o, .bridge_hiz_o(hiz), .anti_surge_o(surge),
    .restart_o(rst_o), .speed_tach_high_o(tach), .motor_locked_o(locked));
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one compare under a mask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] m = 32'hffff_ffff);
    n_checks++;
    if ((got & m) !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got & m, exp);
    end
  endtask
  // classic single cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (i >= 50) begin
      mismatches++;
      $display("[ERR] %0t bus timeout", $time);
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    wb(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask
  // bounded wait for the lock flag, n counts cycles
  task automatic wait_lock(input logic lv);
    n = 0;
    while (locked !== lv && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      $display("[ERR] %0t lock wait timeout", $time);
      end_of_test();
    end
  endtask
  function automatic logic [31:0] mk0(input logic [3:0] ac, input logic [2:0] lk,
      input logic [5:0] en, input logic me, input logic ie, input logic md);
    return {5'h00, md, ie, me, 2'h0, en, 6'h00, 2'h1, 1'h0, lk, ac};
  endfunction
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, masks, read-only and unmapped places
    rd(8'h00, 32'h033f_0135);
    rd(8'h04, 32'h0000_2010);
    rd(8'h08, 32'h0000_0010);
    wb(1'b1, 8'h08, 32'hffff_ffff);
    wb(1'b1, 8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h0000_0010);
    wb(1'b1, 8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h073f_037f);
    wb(1'b1, 8'h04, 32'h0000_1040);
    $display("test map done");
    // mechanical floor: bemf 50 against command 20
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 8'h00, mk0(4'h5, 3'h3, 6'h19, k != 3, 1'b0, k == 1 || k == 2));
      v24 <= (k == 2);
      repeat (6) @(negedge clk_i);
      chk(amp_o, (k == 1 || k == 3) ? 9'h014 : 9'h032);
      chk(surge, (k == 1 || k == 3) ? 1'b0 : 1'b1);
    end
    // start-up cap: 200 mA * 0x40 >> 8 + 40 * 0x10 >> 6 = 60
    wb(1'b1, 8'h00, mk0(4'h1, 3'h3, 6'h19, 1'b1, 1'b0, 1'b0));
    spd <= 9'h028;
    cmd <= 9'h12c;
    repeat (5) @(negedge clk_i);
    chk(amp_o, 9'h12c);
    @(posedge clk_i);
    cl <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk({amp_o, locked}, {9'h03c, 1'b0});
    @(posedge clk_i);
    cl <= 1'b0;
    $display("test amplitude done");
    // low-side trip at 250 mA, inductive surge then retry
    wb(1'b1, 8'h00, mk0(4'h0, 3'h0, 6'h19, 1'b1, 1'b1, 1'b0));
    load <= 12'h12c;
    wait_lock(1'b1);
    chk({hiz, tach, surge}, 3'h7);
    rd(8'h08, 32'h0000_0125, 32'h0000_01ff);
    load <= 12'h0c8;
    wait_lock(1'b0);
    chk(n >= 1000, 1'b1);
    chk(hiz, 1'b0);
    rd(8'h08, 32'h0000_0010);
    // no motor: 100 mA at closed-loop entry
    wb(1'b1, 8'h00, mk0(4'h0, 3'h0, 6'h19, 1'b1, 1'b0, 1'b0));
    load <= 12'h064;
    repeat (2) @(posedge clk_i);
    cl <= 1'b1;
    wait_lock(1'b1);
    rd(8'h08, 32'h0000_0845, 32'h0000_08ff);
    cl <= 1'b0;
    load <= 12'h0c8;
    wait_lock(1'b0);
    // open-loop stuck: two cycles past handoff, no crossings
    @(posedge clk_i);
    ho <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      olc <= (k % 2 == 0);
    end
    wait_lock(1'b1);
    rd(8'h08, 32'h0000_1045, 32'h0000_10ff);
    ho <= 1'b0;
    wait_lock(1'b0);
    $display("test lock0 lock3 lock4 done");
    // closed-loop stall: crossings stop after period 11
    wb(1'b1, 8'h00, mk0(4'h0, 3'h0, 6'h39, 1'b1, 1'b0, 1'b0));
    zper <= 8'h0a;
    cl <= 1'b1;
    repeat (60) @(posedge clk_i);
    zper <= 8'h00;
    wait_lock(1'b1);
    chk(n <= 40, 1'b1);
    rd(8'h08, 32'h0000_2445, 32'h0000_24ff);
    cl <= 1'b0;
    wait_lock(1'b0);
    // abnormal speed: bemf 100 far above amplitude 10
    wb(1'b1, 8'h00, mk0(4'h0, 3'h0, 6'h1b, 1'b0, 1'b0, 1'b0));
    spd <= 9'h190;
    cmd <= 9'h00a;
    cl <= 1'b1;
    wait_lock(1'b1);
    chk(n >= 15 && n <= 40, 1'b1);
    rd(8'h08, 32'h0000_0245, 32'h0000_02ff);
    cl <= 1'b0;
    spd <= 9'h028;
    wait_lock(1'b0);
    // overcurrent floats without a lock, then resumes
    @(posedge clk_i);
    oc <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk({hiz, locked}, 2'h2);
    rd(8'h08, 32'h0000_0006, 32'h0000_0007);
    oc <= 1'b0;
    repeat (5) @(negedge clk_i);
    chk(hiz, 1'b0);
    // disabled scheme still records its cause
    wb(1'b1, 8'h00, mk0(4'h0, 3'h0, 6'h18, 1'b1, 1'b0, 1'b0));
    load <= 12'h12c;
    repeat (6) @(negedge clk_i);
    chk(locked, 1'b0);
    rd(8'h08, 32'h0000_0110, 32'h0000_01ff);
    $display("test lock5 lock1 oc mask done");
    end_of_test();
  end
endmodule
